// [verilog/rtfr_regs.svh]
`ifndef RTFR_REGS_SVH
`define RTFR_REGS_SVH

// Header dword 0 field positions
`define RTFR_FMT_HI         30
`define RTFR_FMT_LO         29
`define RTFR_TYPE_HI        28
`define RTFR_TYPE_LO        24
`define RTFR_TD_BIT         15
`define RTFR_EP_BIT         14
`define RTFR_NOSNOOP_BIT    12

// Packet type codes (type field, 5 bits)
`define RTFR_TYPE_MEM       5'h00
`define RTFR_TYPE_MEMLK     5'h01
`define RTFR_TYPE_IO        5'h02
`define RTFR_TYPE_CFG0      5'h04
`define RTFR_TYPE_CFG1      5'h05

// Message codes (header dword 1, low byte)
`define RTFR_MSG_UNLOCK     8'h00
`define RTFR_MSG_ATS_INV    8'h01
`define RTFR_MSG_PRG_RESP   8'h05
`define RTFR_MSG_PM_PME     8'h18
`define RTFR_MSG_PME_OFF    8'h19
`define RTFR_MSG_PME_ACK    8'h1b
`define RTFR_MSG_INT_BASE   8'h20
`define RTFR_MSG_INT_TOP    8'h27
`define RTFR_MSG_ERR_COR    8'h30
`define RTFR_MSG_ERR_NF     8'h31
`define RTFR_MSG_ERR_FATAL  8'h33

// Configuration space boundaries, dword addresses
`define RTFR_LEGACY_TOP     10'h040
`define RTFR_LEGACY_PTR_MIN 10'h02a
`define RTFR_LEGACY_PTR_MAX 10'h03f

// Receive check policy codes
`define RTFR_ECRC_OFF       2'h0
`define RTFR_ECRC_ALWAYS    2'h1
`define RTFR_ECRC_AER       2'h3

// Digest generator
`define RTFR_CRC_POLY       32'h04c11db7
`define RTFR_CRC_SEED       32'hffffffff

// Pull credits held at most
`define RTFR_NP_CREDIT_MAX  4'hf

`endif

// [verilog/rtfr_pkg.sv]
package rtfr_pkg;

  typedef enum logic [2:0] {
    ST_HDR    = 3'b000,
    ST_DECIDE = 3'b001,
    ST_REPLAY = 3'b010,
    ST_PASS   = 3'b011,
    ST_DROP   = 3'b100,
    ST_FLUSH  = 3'b101
  } rtfr_state_t;

  typedef logic [1:0]  rtfr_ecrc_mode_t;
  typedef logic [31:0] rtfr_dword_t;
  typedef logic [9:0]  rtfr_cfg_addr_t;

endpackage

// [verilog/rtfr_fifo.sv]
`timescale 1ns/1ps
module rtfr_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  wire              wrFire = inValid && inReady;
  wire              rdFire = outValid && outReady;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  always_ff @(posedge clk) begin
    if (wrFire) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (wrFire) wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      if (rdFire) rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(wrFire) - (AW+1)'(rdFire);
    end
  end
endmodule // rtfr_fifo

// [verilog/rtfr_ecrc.sv]
`timescale 1ns/1ps
`include "rtfr_regs.svh"
module rtfr_ecrc (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           wordFire,
  input  wire logic           wordSop,
  input  wire logic           wordEop,
  input  wire logic [31:0]    wordData,
  input  wire logic           checkOn,
  output logic                ecrcError
);
  import rtfr_pkg::*;

  rtfr_dword_t crc_q;
  logic        td_q;
  rtfr_dword_t crcIn;
  rtfr_dword_t crcNext;
  rtfr_dword_t seed;

  // Variant bits (type bit 0, poison) count as ones so a switch may alter them
  assign crcIn = wordSop ? (wordData | 32'h01004000) : wordData;
  assign seed  = wordSop ? `RTFR_CRC_SEED : crc_q;

  always_comb begin
    crcNext = seed;
    for (int i = 31; i >= 0; i--) begin
      crcNext = (crcNext[31] ^ crcIn[i]) ? ((crcNext << 1) ^ `RTFR_CRC_POLY) : (crcNext << 1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crc_q     <= `RTFR_CRC_SEED;
      td_q      <= 1'b0;
      ecrcError <= 1'b0;
    end else begin
      ecrcError <= 1'b0;
      if (wordFire) begin
        if (wordSop) td_q <= wordData[`RTFR_TD_BIT];
        if (wordEop) begin
          ecrcError <= td_q && checkOn && (~crc_q != wordData);
        end else begin
          crc_q <= crcNext;
        end
      end
    end
  end
endmodule // rtfr_ecrc

// [verilog/rtfr_filter_router.sv]
`timescale 1ns/1ps
`include "rtfr_regs.svh"
module rtfr_filter_router (
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Receive packets from the link side, one dword a beat
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [31:0]              inData,
  input  wire logic                     inEop,
  // Streaming receive interface towards the user
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic      [31:0]              outData,
  output logic                          outSop,
  output logic                          outEop,
  // Configuration
  input  wire logic                     rootPort,
  input  wire logic                     legacyCfgEnable,
  input  wire rtfr_pkg::rtfr_cfg_addr_t legacyCfgPointer,
  input  wire logic                     extCfgEnable,
  input  wire rtfr_pkg::rtfr_cfg_addr_t extCfgPointer,
  input  wire logic                     rejectSnoop,
  input  wire rtfr_pkg::rtfr_ecrc_mode_t ecrcCheckMode,
  input  wire logic                     aerEcrcCheckEnable,
  input  wire logic                     trimDigest,
  input  wire logic                     suppressPoisonResp,
  input  wire logic                     messageRouting,
  input  wire logic                     invalidate_to_unsupported,
  input  wire logic                     page_group_response_to_unsupported,
  // Non-posted metering
  input  wire logic                     npPullMode,
  input  wire logic                     nonposted_pull_request,
  input  wire logic                     nonposted_accept_allowed,
  // Events, one-cycle pulses
  output logic                          urDetected,
  output logic                          cfgCompletedInside,
  output logic                          msgConsumedInside,
  output logic                          poisonedReport,
  output logic                          ecrcError
);
  import rtfr_pkg::*;

  rtfr_state_t state_q;
  rtfr_state_t state_d;
  rtfr_dword_t hdr_q [3];
  logic [1:0]  hdrCnt_q;
  logic [1:0]  rpCnt_q;
  logic        hdrEop_q;
  logic [3:0]  npCredit_q;
  rtfr_dword_t pend_q;
  logic        pendValid_q;
  logic        pendSop_q;
  logic        pendEop_q;
  logic        trim_q;

  // Header decode
  wire [1:0]   fmt      = hdr_q[0][`RTFR_FMT_HI:`RTFR_FMT_LO];
  wire [4:0]   tlpType  = hdr_q[0][`RTFR_TYPE_HI:`RTFR_TYPE_LO];
  wire [7:0]   msgCode  = hdr_q[1][7:0];
  wire         isMem    = (tlpType == `RTFR_TYPE_MEM) || (tlpType == `RTFR_TYPE_MEMLK);
  wire         isIo     = (tlpType == `RTFR_TYPE_IO);
  wire         isCfg    = (tlpType == `RTFR_TYPE_CFG0) || (tlpType == `RTFR_TYPE_CFG1);
  wire         isMsg    = (tlpType[4:3] == 2'b10);
  wire         isNp     = isCfg || isIo || (isMem && !fmt[1]);
  wire         poisoned = hdr_q[0][`RTFR_EP_BIT];
  wire         hasTd    = hdr_q[0][`RTFR_TD_BIT];
  wire rtfr_cfg_addr_t cfgAddr = hdr_q[2][11:2];

  // Config routing
  wire         legacyPtrOk = (legacyCfgPointer >= `RTFR_LEGACY_PTR_MIN) &&
                             (legacyCfgPointer <= `RTFR_LEGACY_PTR_MAX);
  wire         cfgLegacyUser = legacyCfgEnable && legacyPtrOk && (cfgAddr < `RTFR_LEGACY_TOP) &&
                               (cfgAddr >= legacyCfgPointer);
  wire         cfgExtUser = extCfgEnable && (cfgAddr >= `RTFR_LEGACY_TOP) &&
                            (cfgAddr >= extCfgPointer);
  wire         cfgToUser = cfgLegacyUser || cfgExtUser;

  // Message routing
  wire         msgEp  = (msgCode == `RTFR_MSG_UNLOCK) || (msgCode == `RTFR_MSG_PME_OFF);
  wire         msgInt = (msgCode >= `RTFR_MSG_INT_BASE) && (msgCode <= `RTFR_MSG_INT_TOP);
  wire         msgRp  = (msgCode == `RTFR_MSG_ERR_COR) || (msgCode == `RTFR_MSG_ERR_NF) ||
                        (msgCode == `RTFR_MSG_ERR_FATAL) || msgInt ||
                        (msgCode == `RTFR_MSG_PM_PME) || (msgCode == `RTFR_MSG_PME_ACK);
  wire         msgAtsInv = (msgCode == `RTFR_MSG_ATS_INV);
  wire         msgPrg    = (msgCode == `RTFR_MSG_PRG_RESP);
  wire         msgInside = rootPort ? (msgRp && !messageRouting)
                                    : (msgEp && !messageRouting);
  wire         msgUr = (msgAtsInv && invalidate_to_unsupported) ||
                       (msgPrg && page_group_response_to_unsupported);

  // Snoop rejection applies to memory requests only
  wire         snoopUr = rootPort && rejectSnoop && isMem && !hdr_q[0][`RTFR_NOSNOOP_BIT];

  wire         dropUr     = snoopUr || (isMsg && msgUr);
  wire         dropCfg    = isCfg && !cfgToUser;
  wire         dropMsg    = isMsg && !msgUr && msgInside;
  wire         dropAny    = dropUr || dropCfg || dropMsg;

  // Only one metering style is honoured at a time; the mode input picks it
  wire         npAllowed = npPullMode ? (npCredit_q != 4'h0) : nonposted_accept_allowed;
  wire         npBlocked = isNp && !npAllowed;
  wire         startPass = (state_q == ST_DECIDE) && !dropAny && !npBlocked;
  wire         npTake    = startPass && isNp && npPullMode;

  wire         checkOn = (ecrcCheckMode == `RTFR_ECRC_ALWAYS) ||
                         ((ecrcCheckMode == `RTFR_ECRC_AER) && aerEcrcCheckEnable);

  // Write stage: one dword held back so the trailing digest can be removed
  logic        fifoInReady;
  logic        wordValid;
  rtfr_dword_t wordData;
  logic        wordEop;
  logic        wordSop;
  wire         flushing   = (state_q == ST_FLUSH);
  wire         stageReady = !pendValid_q || fifoInReady;
  wire         wordFire   = wordValid && stageReady;
  wire         trimNow    = wordFire && wordEop && trim_q;
  wire         fifoWr     = pendValid_q && (wordValid || flushing);
  wire         fifoWrEop  = pendEop_q || trimNow;
  wire         flushDone  = flushing && (!pendValid_q || fifoInReady);

  wire         hdrFire  = (state_q == ST_HDR) && inValid;
  wire         passFire = (state_q == ST_PASS) && inValid && stageReady;
  wire         inFire   = inValid && inReady;

  assign inReady = (state_q == ST_HDR) || (state_q == ST_DROP) ||
                   ((state_q == ST_PASS) && stageReady);

  always_comb begin
    wordValid = 1'b0;
    wordData  = inData;
    wordEop   = inEop;
    wordSop   = 1'b0;
    if (state_q == ST_REPLAY) begin
      wordValid = 1'b1;
      wordData  = hdr_q[rpCnt_q];
      wordEop   = (rpCnt_q == 2'd2) && hdrEop_q;
      wordSop   = (rpCnt_q == 2'd0);
      if (rpCnt_q == 2'd0 && trim_q) begin
        wordData[`RTFR_TD_BIT] = 1'b0;
      end
    end else if (state_q == ST_PASS) begin
      wordValid = inValid;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HDR: begin
        if (hdrFire && (inEop || hdrCnt_q == 2'd2)) begin
          state_d = (hdrCnt_q == 2'd2) ? ST_DECIDE : ST_HDR;
        end
      end
      ST_DECIDE: begin
        if (dropAny) begin
          state_d = hdrEop_q ? ST_HDR : ST_DROP;
        end else if (!npBlocked) begin
          state_d = ST_REPLAY;
        end
      end
      ST_REPLAY: begin
        if (wordFire && rpCnt_q == 2'd2) begin
          state_d = hdrEop_q ? (trimNow ? ST_HDR : ST_FLUSH) : ST_PASS;
        end
      end
      ST_PASS: begin
        if (passFire && inEop) begin
          state_d = trimNow ? ST_HDR : ST_FLUSH;
        end
      end
      ST_DROP: begin
        if (inFire && inEop) begin
          state_d = ST_HDR;
        end
      end
      ST_FLUSH: begin
        if (flushDone) begin
          state_d = ST_HDR;
        end
      end
      default: state_d = ST_HDR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= ST_HDR;
      hdrCnt_q <= 2'd0;
      rpCnt_q  <= 2'd0;
      hdrEop_q <= 1'b0;
      trim_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (hdrFire) begin
        hdrCnt_q <= (inEop || hdrCnt_q == 2'd2) ? 2'd0 : hdrCnt_q + 2'd1;
        hdrEop_q <= inEop;
      end
      if (state_q == ST_DECIDE) begin
        rpCnt_q <= 2'd0;
        trim_q  <= trimDigest && hasTd;
      end else if (state_q == ST_REPLAY && wordFire) begin
        rpCnt_q <= rpCnt_q + 2'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (hdrFire) begin
      hdr_q[hdrCnt_q] <= inData;
    end
  end

  // Credit count saturates; extra pulls beyond the ceiling are lost
  always_ff @(posedge clk) begin
    if (reset) begin
      npCredit_q <= 4'h0;
    end else if (nonposted_pull_request && !npTake && npCredit_q != `RTFR_NP_CREDIT_MAX) begin
      npCredit_q <= npCredit_q + 4'h1;
    end else if (npTake && !nonposted_pull_request) begin
      npCredit_q <= npCredit_q - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q      <= 32'h00000000;
      pendValid_q <= 1'b0;
      pendSop_q   <= 1'b0;
      pendEop_q   <= 1'b0;
    end else if (wordFire) begin
      pend_q      <= wordData;
      pendValid_q <= !trimNow;
      pendSop_q   <= wordSop;
      pendEop_q   <= wordEop;
    end else if (flushDone) begin
      pendValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      urDetected         <= 1'b0;
      cfgCompletedInside <= 1'b0;
      msgConsumedInside  <= 1'b0;
      poisonedReport     <= 1'b0;
    end else begin
      urDetected         <= (state_q == ST_DECIDE) && dropUr;
      cfgCompletedInside <= (state_q == ST_DECIDE) && dropCfg && !dropUr;
      msgConsumedInside  <= (state_q == ST_DECIDE) && dropMsg && !dropUr;
      poisonedReport     <= (state_q == ST_DECIDE) && !npBlocked && poisoned &&
                            !suppressPoisonResp;
    end
  end

  rtfr_ecrc u_ecrc (
    .clk       (clk),
    .reset     (reset),
    .wordFire  (inFire),
    .wordSop   (hdrFire && hdrCnt_q == 2'd0),
    .wordEop   (inEop),
    .wordData  (inData),
    .checkOn   (checkOn),
    .ecrcError (ecrcError)
  );

  logic [33:0] fifoOut;

  rtfr_fifo #(
    .WIDTH (34),
    .DEPTH (4)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (fifoWr),
    .inReady  (fifoInReady),
    .inData   ({pendSop_q, fifoWrEop, pend_q}),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (fifoOut)
  );

  assign outSop  = fifoOut[33];
  assign outEop  = fifoOut[32];
  assign outData = fifoOut[31:0];
endmodule // rtfr_filter_router

// [bench/rtfr_asserts.sv]
`timescale 1ns/1ps
module rtfr_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        outValid,
  input wire logic        outReady,
  input wire logic [31:0] outData,
  input wire logic        outSop,
  input wire logic        outEop,
  input wire logic        rootPort,
  input wire logic        legacyCfgEnable,
  input wire logic        extCfgEnable,
  input wire logic        rejectSnoop,
  input wire logic        trimDigest,
  input wire logic        suppressPoisonResp,
  input wire logic        messageRouting,
  input wire logic        invalidate_to_unsupported,
  input wire logic        page_group_response_to_unsupported,
  input wire logic        npPullMode,
  input wire logic        nonposted_pull_request,
  input wire logic        poisonedReport
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       msgHdr_q;
  logic [4:0] credit_q;
  wire        take  = outValid && outReady;
  wire  [4:0] ty    = outData[28:24];
  wire        isCfg = outSop && ty[4:1] == 4'h2;
  wire        isNp  = isCfg || outSop && (ty == 5'h02 || ty == 5'h00 && !outData[30]);
  wire  [7:0] code  = outData[7:0];
  // Credits restart whenever pull mode is off, so modes may only change while idle
  always_ff @(posedge clk) begin
    if (reset || !npPullMode) begin
      credit_q <= 5'h00;
    end else begin
      credit_q <= credit_q + {4'h0, nonposted_pull_request} - {4'h0, take && isNp};
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      msgHdr_q <= 1'h0;
    end else if (take) begin
      msgHdr_q <= outSop && ty[4:3] == 2'h2;
    end
  end
  sequence s_stall; outValid && !outReady; endsequence
  sequence s_code; take && msgHdr_q; endsequence
  property p_hold; s_stall |=> outValid && $stable(outData) && $stable(outSop) && $stable(outEop); endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  property p_cfg_off; take && isCfg |-> legacyCfgEnable || extCfgEnable; endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("config request with routing off");
  property p_snoop; take && outSop && ty == 5'h00 && rootPort && rejectSnoop |-> outData[12]; endproperty
  a_snoop: assert property (p_snoop) else $error("snoop request not rejected");
  property p_trim; take && outSop && trimDigest |-> !outData[15]; endproperty
  a_trim: assert property (p_trim) else $error("digest flag left set");
  property p_poison; suppressPoisonResp |-> !poisonedReport; endproperty
  a_poison: assert property (p_poison) else $error("poison reported while suppressed");
  property p_ep_msg; s_code ##0 !rootPort && !messageRouting |-> code != 8'h00 && code != 8'h19; endproperty
  a_ep_msg: assert property (p_ep_msg) else $error("message delivered with routing off");
  property p_pull; take && isNp && npPullMode |-> credit_q != 5'h00; endproperty
  a_pull: assert property (p_pull) else $error("non-posted packet without pull");
  property p_inv; s_code ##0 invalidate_to_unsupported |-> code != 8'h01; endproperty
  a_inv: assert property (p_inv) else $error("invalidate delivered");
  property p_prg; s_code ##0 page_group_response_to_unsupported |-> code != 8'h05; endproperty
  a_prg: assert property (p_prg) else $error("group response delivered");
endmodule // rtfr_asserts
bind rtfr_filter_router rtfr_asserts chk (.clk, .reset, .outValid, .outReady, .outData, .outSop, .outEop, .rootPort,
  .legacyCfgEnable, .extCfgEnable, .rejectSnoop, .trimDigest, .suppressPoisonResp, .messageRouting,
  .invalidate_to_unsupported, .page_group_response_to_unsupported, .npPullMode, .nonposted_pull_request,
  .poisonedReport);

// [bench/rtfr_user_model.sv]
`timescale 1ns/1ps
module rtfr_user_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        outValid,
  output logic             outReady,
  input  wire logic [31:0] outData,
  input  wire logic        outSop,
  input  wire logic        outEop,
  output logic             nonposted_pull_request,
  output logic             nonposted_accept_allowed,
  input  wire logic [1:0]  stall,
  input  wire logic        usePull,
  input  wire logic        askOne,
  input  wire logic        openNp
);
  logic [31:0] rx[$];
  logic [1:0]  mk[$];
  int          pkts;
  logic        tog_q;
  // Stall 0 takes every cycle, 1 every other cycle, 2 never
  assign outReady = stall == 2'h0 || stall == 2'h1 && tog_q;
  // Throttle level is held low whenever pull requests are in use
  assign nonposted_accept_allowed = openNp && !usePull;
  always @(posedge clk) begin
    tog_q <= reset ? 1'h0 : !tog_q;
    nonposted_pull_request <= !reset && usePull && askOne;
    if (reset) begin
      pkts <= 0;
    end else if (outValid && outReady) begin
      // Unbounded store, so late packets after closing the level always fit
      rx.push_back(outData);
      mk.push_back({outSop, outEop});
      if (outEop) begin
        pkts <= pkts + 1;
      end
    end
  end
endmodule // rtfr_user_model

// [bench/rtfr_filter_router_bench.sv]
`timescale 1ns/1ps
module rtfr_filter_router_bench;
  import rtfr_pkg::*;
  logic            clk, reset, inValid, inReady, inEop, outValid, outReady, outSop, outEop, usePull, askOne, openNp;
  logic [31:0]     inData, outData;
  logic            rootPort, legacyCfgEnable, extCfgEnable, rejectSnoop, aerEcrcCheckEnable, trimDigest;
  logic            suppressPoisonResp, messageRouting, invalidate_to_unsupported, page_group_response_to_unsupported;
  logic            npPullMode, nonposted_pull_request, nonposted_accept_allowed;
  logic            urDetected, cfgCompletedInside, msgConsumedInside, poisonedReport, ecrcError;
  logic [1:0]      stall;
  rtfr_cfg_addr_t  legacyCfgPointer, extCfgPointer;
  rtfr_ecrc_mode_t ecrcCheckMode;
  int              err_count, n_checks, cycles, nUr, nCfg, nMsg, nPoison, nEcrc, p0, e0, b, r;
  logic [31:0]     pk[$];
  logic [8:0]      msgTab[15];
  logic [3:0]      ecTab[5];
  rtfr_filter_router uut (.clk, .reset, .inValid, .inReady, .inData, .inEop, .outValid, .outReady, .outData,
    .outSop, .outEop, .rootPort, .legacyCfgEnable, .legacyCfgPointer, .extCfgEnable, .extCfgPointer, .rejectSnoop,
    .ecrcCheckMode, .aerEcrcCheckEnable, .trimDigest, .suppressPoisonResp, .messageRouting,
    .invalidate_to_unsupported, .page_group_response_to_unsupported, .npPullMode, .nonposted_pull_request,
    .nonposted_accept_allowed, .urDetected, .cfgCompletedInside, .msgConsumedInside, .poisonedReport, .ecrcError);
  rtfr_user_model um (.clk, .reset, .outValid, .outReady, .outData, .outSop, .outEop, .nonposted_pull_request,
    .nonposted_accept_allowed, .stall, .usePull, .askOne, .openNp);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    nUr <= nUr + int'(urDetected);
    nCfg <= nCfg + int'(cfgCompletedInside);
    nMsg <= nMsg + int'(msgConsumedInside);
    nPoison <= nPoison + int'(poisonedReport);
    nEcrc <= nEcrc + int'(ecrcError);
    // Tests need under two thousand cycles; this ceiling only catches a hang
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] hd(logic [1:0] f, logic [4:0] t, logic td, logic ep, logic ns);
    return {1'h0, f, t, 8'h00, td, ep, 1'h0, ns, 12'h001};
  endfunction
  function automatic int act();
    return um.pkts + nUr + nCfg + nMsg;
  endfunction
  // Ready is judged at the falling edge, where it has settled
  task automatic send();
    int t;
    foreach (pk[j]) begin
      inValid = 1'h1;
      inData = pk[j];
      inEop = j == pk.size() - 1;
      for (t = 0; t < 300; t++) begin
        @(negedge clk);
        if (inReady === 1'h1) break;
      end
      idle(1);
    end
    inValid = 1'h0;
    inEop = 1'h0;
  endtask
  // Outcome k: 0 delivered, 1 unsupported, 2 config kept inside, 3 message kept inside
  task automatic run(int k, int len);
    int s0, s1, s2, s3, t;
    s0 = um.pkts;
    s1 = nUr;
    s2 = nCfg;
    s3 = nMsg;
    p0 = nPoison;
    e0 = nEcrc;
    um.rx.delete();
    um.mk.delete();
    send();
    for (t = 0; t < 200 && act() == s0 + s1 + s2 + s3; t++) idle(1);
    idle(6);
    chk("delivered", s0 + (k == 0), um.pkts);
    chk("unsupported", s1 + (k == 1), nUr);
    chk("config inside", s2 + (k == 2), nCfg);
    chk("message inside", s3 + (k == 3), nMsg);
    if (k == 0) chk("length", len, um.rx.size());
  endtask
  task automatic cfgCase(logic le, logic [9:0] lp, logic ee, logic [9:0] ep, logic [9:0] a, int k);
    legacyCfgEnable = le;
    legacyCfgPointer = lp;
    extCfgEnable = ee;
    extCfgPointer = ep;
    pk = '{hd(2'h0, 5'h04, 1'h0, 1'h0, 1'h0), 32'h0, {20'h00000, a, 2'h0}};
    run(k, 3);
  endtask
  task automatic msgRun(logic [7:0] code, int k);
    pk = '{hd(2'h1, 5'h10, 1'h0, 1'h0, 1'h0), {24'h000000, code}, 32'h0, 32'h0};
    run(k, 4);
  endtask
  task automatic pull();
    askOne = 1'h1;
    idle(1);
    askOne = 1'h0;
  endtask
  initial begin
    {clk, inValid, inData, inEop, rootPort, legacyCfgEnable, legacyCfgPointer, extCfgEnable, extCfgPointer} = '0;
    {rejectSnoop, ecrcCheckMode, aerEcrcCheckEnable, trimDigest, suppressPoisonResp, messageRouting} = '0;
    {invalidate_to_unsupported, page_group_response_to_unsupported, npPullMode, usePull, askOne, stall} = '0;
    reset = 1'h1;
    openNp = 1'h1;
    msgTab = '{9'h000, 9'h019, 9'h130, 9'h131, 9'h133, 9'h118, 9'h11b, 9'h120, 9'h121, 9'h122, 9'h123,
               9'h124, 9'h125, 9'h126, 9'h127};
    ecTab = '{4'h2, 4'h5, 4'hc, 4'hf, 4'ha};
    repeat (16) @(posedge clk);
    #1;
    reset = 1'h0;
    idle(1);
    cfgCase(1'h1, 10'h02a, 1'h0, 10'h000, 10'h02a, 0);
    cfgCase(1'h1, 10'h02a, 1'h0, 10'h000, 10'h029, 2);
    cfgCase(1'h1, 10'h03f, 1'h0, 10'h000, 10'h03f, 0);
    cfgCase(1'h1, 10'h029, 1'h0, 10'h000, 10'h02a, 2);
    cfgCase(1'h1, 10'h040, 1'h0, 10'h000, 10'h03f, 2);
    cfgCase(1'h0, 10'h02a, 1'h0, 10'h000, 10'h030, 2);
    cfgCase(1'h0, 10'h000, 1'h1, 10'h100, 10'h100, 0);
    cfgCase(1'h0, 10'h000, 1'h1, 10'h100, 10'h0ff, 2);
    cfgCase(1'h0, 10'h000, 1'h0, 10'h100, 10'h100, 2);
    $display("test config routing done");
    for (r = 0; r < 2; r++) begin
      messageRouting = r[0];
      foreach (msgTab[j]) begin
        rootPort = msgTab[j][8];
        msgRun(msgTab[j][7:0], r == 1 ? 0 : 3);
      end
    end
    rootPort = 1'h0;
    messageRouting = 1'h0;
    msgRun(8'h30, 0);
    for (r = 0; r < 2; r++) begin
      invalidate_to_unsupported = r[0];
      page_group_response_to_unsupported = !r[0];
      msgRun(8'h01, r);
      msgRun(8'h05, 1 - r);
    end
    $display("test messages done");
    rejectSnoop = 1'h1;
    for (r = 0; r < 3; r++) begin
      rootPort = r != 2;
      pk = '{hd(2'h2, 5'h00, 1'h0, 1'h0, r == 1), 32'h0, 32'h1000, 32'h1234abcd};
      run(r == 0 ? 1 : 0, 4);
    end
    rootPort = 1'h0;
    foreach (ecTab[j]) begin
      {ecrcCheckMode, aerEcrcCheckEnable} = ecTab[j][3:1];
      pk = '{hd(2'h2, 5'h00, 1'h1, 1'h0, 1'h1), 32'h0, 32'h1000, 32'h1234abcd, 32'hdeadbeef};
      run(0, 5);
      chk("digest error", ecTab[j][0], nEcrc - e0);
    end
    ecrcCheckMode = 2'h0;
    trimDigest = 1'h1;
    run(0, 4);
    chk("trimmed header", hd(2'h2, 5'h00, 1'h0, 1'h0, 1'h1), um.rx[0]);
    chk("trimmed end", 2'h1, um.mk[3]);
    trimDigest = 1'h0;
    for (r = 0; r < 2; r++) begin
      suppressPoisonResp = r[0];
      pk = '{hd(2'h2, 5'h00, 1'h0, 1'h1, 1'h1), 32'h0, 32'h1000, 32'h1234abcd};
      run(0, 4);
      chk("poison report", !r[0], nPoison - p0);
    end
    $display("test checks and options done");
    npPullMode = 1'h1;
    usePull = 1'h1;
    pk = '{hd(2'h0, 5'h00, 1'h0, 1'h0, 1'h1), 32'h0, 32'h1000};
    b = um.pkts;
    send();
    idle(20);
    chk("held without pull", b, um.pkts);
    pull();
    send();
    idle(40);
    chk("one per pull", b + 1, um.pkts);
    pull();
    idle(40);
    chk("second pull", b + 2, um.pkts);
    npPullMode = 1'h0;
    usePull = 1'h0;
    openNp = 1'h0;
    send();
    idle(20);
    chk("held while closed", b + 2, um.pkts);
    openNp = 1'h1;
    idle(40);
    chk("released when open", b + 3, um.pkts);
    $display("test non-posted metering done");
    pk = '{hd(2'h2, 5'h00, 1'h0, 1'h0, 1'h1), 32'h0, 32'h1000, 32'h11, 32'h22, 32'h33, 32'h44, 32'h55, 32'h66};
    stall = 2'h2;
    fork
      run(0, 9);
      begin
        idle(30);
        chk("input while full", 1'h0, inReady);
        stall = 2'h1;
      end
    join
    foreach (pk[j]) chk("dword order", pk[j], um.rx[j]);
    foreach (pk[j]) chk("marks", j == 0 ? 2 : j == 8, um.mk[j]);
    chk("drained", 1'h0, outValid);
    $display("test buffering done");
    final_report();
  end
endmodule // rtfr_filter_router_bench
